/* File: design/tsd_pkg.sv */
package tsd_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 8;
    localparam int DLY_W      = 5;
    localparam int CNT_W      = 7;
    localparam int TRIM_COUNT = 4;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [ADDR_W-1:0] OFS_TRIM_A = 8'h7E;
    localparam logic [ADDR_W-1:0] OFS_TRIM_B = 8'h7F;
    localparam logic [ADDR_W-1:0] OFS_TRIM_C = 8'h80;
    localparam logic [ADDR_W-1:0] OFS_TRIM_D = 8'h81;
    localparam logic [ADDR_W-1:0] OFS_OVL    = 8'h9A;
    localparam logic [ADDR_W-1:0] OFS_MUX    = 8'h9B;
    localparam logic [ADDR_W-1:0] OFS_NOISE  = 8'h9D;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int DLY_LSB = 0;

    // ****************************************************************
    // Values after reset
    // ****************************************************************
    localparam logic [DATA_W-1:0] RST_TRIM    = 8'h00;
    localparam logic [DATA_W-1:0] RST_OVL     = 8'h08;
    localparam logic [DATA_W-1:0] RST_MUX     = 8'h07;
    localparam logic [DATA_W-1:0] RST_NOISE   = 8'h00;
    localparam logic [DATA_W-1:0] RD_UNMAPPED = 8'h00;
    localparam logic [CNT_W-1:0]  RST_CNT     = 7'h00;
    localparam logic [DLY_W-1:0]  RST_DLY     = 5'h00;

    // ****************************************************************
    // Cycle counts
    // ****************************************************************
    localparam logic [CNT_W-1:0] SWAP_BASE_CYC = 7'h04;
    localparam logic [CNT_W-1:0] CNT_STEP      = 7'h01;

endpackage : tsd_pkg

/* File: design/tsd_regs.sv */
`timescale 1ns/1ps
module tsd_regs
(
    // Clock, reset and enable
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    input  wire logic                      clk_en,
    // Register port
    input  wire logic [tsd_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [tsd_pkg::DATA_W-1:0] wr_data,
    input  wire logic                      wr_en,
    input  wire logic                      rd_en,
    output logic      [tsd_pkg::DATA_W-1:0] rd_data,
    // Fuse storage
    input  wire logic [tsd_pkg::DATA_W-1:0] fuse_trim_a,
    input  wire logic [tsd_pkg::DATA_W-1:0] fuse_trim_b,
    input  wire logic [tsd_pkg::DATA_W-1:0] fuse_trim_c,
    input  wire logic [tsd_pkg::DATA_W-1:0] fuse_trim_d,
    // Calibration engine
    input  wire logic                      swap_start,
    input  wire logic                      swap_target,
    input  wire logic                      steer_req,
    // Settings to the analog front end
    output logic      [tsd_pkg::DATA_W-1:0] trim_a,
    output logic      [tsd_pkg::DATA_W-1:0] trim_b,
    output logic      [tsd_pkg::DATA_W-1:0] trim_c,
    output logic      [tsd_pkg::DATA_W-1:0] trim_d,
    output logic      [tsd_pkg::DATA_W-1:0] noise_ctrl,
    // Swap state
    output logic                           overlap_active,
    output logic                           steer_sel,
    output logic                           swap_busy
);
    import tsd_pkg::*;

    // ****************************************************************
    // Reset release
    // ****************************************************************
    // Reset asserts at once but releases on the clock, so no register
    // sees a release close to an edge.
    logic rst_meta_reg;
    logic rst_int_n;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_int_n    <= 1'b0;
        end
        else if (clk_en)
        begin
            rst_meta_reg <= 1'b1;
            rst_int_n    <= rst_meta_reg;
        end
    end

    // ****************************************************************
    // Fuse load
    // ****************************************************************
    // Fuse values cannot enter through the asynchronous reset, so the
    // trims are loaded on the first enabled edge after release.
    logic                  fuse_load_reg;
    logic [DATA_W-1:0]     fuse_trim [TRIM_COUNT];
    logic [DATA_W-1:0]     trim_reg  [TRIM_COUNT];

    assign fuse_trim[0] = fuse_trim_a;
    assign fuse_trim[1] = fuse_trim_b;
    assign fuse_trim[2] = fuse_trim_c;
    assign fuse_trim[3] = fuse_trim_d;

    always_ff @(posedge clk_sys or negedge rst_int_n)
    begin
        if (!rst_int_n)
            fuse_load_reg <= 1'b1;
        else if (clk_en)
            fuse_load_reg <= 1'b0;
    end

    // ****************************************************************
    // Termination trims
    // ****************************************************************
    // A write in the load cycle wins, so software is never overwritten.
    genvar gi;
    generate
        for (gi = 0; gi < TRIM_COUNT; gi++)
        begin : g_trim
            localparam logic [ADDR_W-1:0] OFS = OFS_TRIM_A + ADDR_W'(gi);

            always_ff @(posedge clk_sys or negedge rst_int_n)
            begin
                if (!rst_int_n)
                    trim_reg[gi] <= RST_TRIM;
                else if (clk_en)
                begin
                    if (wr_en && reg_addr == OFS)
                        trim_reg[gi] <= wr_data;
                    else if (fuse_load_reg)
                        trim_reg[gi] <= fuse_trim[gi];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Swap delay and noise settings
    // ****************************************************************
    // The upper bits are stored as written; software keeps them at zero.
    logic [DATA_W-1:0] ovl_reg;
    logic [DATA_W-1:0] mux_reg;
    logic [DATA_W-1:0] noise_reg;

    always_ff @(posedge clk_sys or negedge rst_int_n)
    begin
        if (!rst_int_n)
            ovl_reg <= RST_OVL;
        else if (clk_en && wr_en && reg_addr == OFS_OVL)
            ovl_reg <= wr_data;
    end

    always_ff @(posedge clk_sys or negedge rst_int_n)
    begin
        if (!rst_int_n)
            mux_reg <= RST_MUX;
        else if (clk_en && wr_en && reg_addr == OFS_MUX)
            mux_reg <= wr_data;
    end

    always_ff @(posedge clk_sys or negedge rst_int_n)
    begin
        if (!rst_int_n)
            noise_reg <= RST_NOISE;
        else if (clk_en && wr_en && reg_addr == OFS_NOISE)
            noise_reg <= wr_data;
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    // Data stand for one cycle only; an idle or unmapped read gives zero.
    logic [DATA_W-1:0] rd_next;
    logic [DATA_W-1:0] rd_reg;

    always_comb
    begin
        rd_next = RD_UNMAPPED;
        if (rd_en)
        begin
            case (reg_addr)
                OFS_TRIM_A: rd_next = trim_reg[0];
                OFS_TRIM_B: rd_next = trim_reg[1];
                OFS_TRIM_C: rd_next = trim_reg[2];
                OFS_TRIM_D: rd_next = trim_reg[3];
                OFS_OVL:    rd_next = ovl_reg;
                OFS_MUX:    rd_next = mux_reg;
                OFS_NOISE:  rd_next = noise_reg;
                default:    rd_next = RD_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_int_n)
    begin
        if (!rst_int_n)
            rd_reg <= RD_UNMAPPED;
        else if (clk_en)
            rd_reg <= rd_next;
    end

    // ****************************************************************
    // Swap timing
    // ****************************************************************
    // The calibration engine must not start a swap while software is
    // still changing the overlap delay; that is left to its enable.
    tsd_swap_timer u_swap
    (
        .clk_sys        (clk_sys),
        .rst_n          (rst_int_n),
        .clk_en         (clk_en),
        .swap_start     (swap_start),
        .swap_target    (swap_target),
        .steer_req      (steer_req),
        .ovl_dly        (ovl_reg[DLY_LSB +: DLY_W]),
        .mux_dly        (mux_reg[DLY_LSB +: DLY_W]),
        .overlap_active (overlap_active),
        .steer_sel      (steer_sel),
        .swap_busy      (swap_busy)
    );

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign rd_data    = rd_reg;
    assign trim_a     = trim_reg[0];
    assign trim_b     = trim_reg[1];
    assign trim_c     = trim_reg[2];
    assign trim_d     = trim_reg[3];
    assign noise_ctrl = noise_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_int_n);

    sequence s_release;
        $rose(rst_int_n);
    endsequence

    sequence s_fuse_cycle;
        clk_en && fuse_load_reg && !wr_en && rst_int_n;
    endsequence

    chk_delay_reset: assert property (
        s_release |-> ovl_reg == RST_OVL && mux_reg == RST_MUX
            && fuse_load_reg)
        else $error("Delay registers left reset with wrong values.");
    chk_fuse_load: assert property (
        s_fuse_cycle |=> trim_reg[0] == $past(fuse_trim_a)
            && trim_reg[3] == $past(fuse_trim_d) && !fuse_load_reg)
        else $error("Trims were not loaded from the fuses.");
    chk_trim_write: assert property (
        clk_en && wr_en && reg_addr == OFS_TRIM_B
            |=> trim_reg[1] == $past(wr_data))
        else $error("Trim write was not stored.");
    chk_trim_readback: assert property (
        clk_en && rd_en && reg_addr == OFS_TRIM_C
            |=> rd_reg == $past(trim_reg[2]))
        else $error("Trim read returned the wrong value.");
    chk_ovl_write: assert property (
        clk_en && wr_en && reg_addr == OFS_OVL
            |=> ovl_reg == $past(wr_data) ##1 !$past(clk_en)
                || !$past(rd_en) || $past(reg_addr) != OFS_OVL
                || rd_reg == ovl_reg)
        else $error("Overlap delay write was not stored.");
    chk_mux_write: assert property (
        clk_en && wr_en && reg_addr == OFS_MUX
            |=> mux_reg[DLY_LSB +: DLY_W] == $past(wr_data[DLY_LSB +: DLY_W]))
        else $error("Mux delay did not accept the value.");
    chk_read_pulse: assert property (
        clk_en && !rd_en |=> rd_reg == RD_UNMAPPED)
        else $error("Read data stood longer than one cycle.");
    chk_unmapped_read: assert property (
        clk_en && rd_en && reg_addr == OFS_MUX + ADDR_W'(1)
            |=> rd_reg == RD_UNMAPPED)
        else $error("Unmapped read did not return zero.");

    sequence s_frozen;
        !clk_en;
    endsequence

    // A low enable must hold every register, the read data included.
    chk_trim_freeze: assert property (
        s_frozen |=> $stable(trim_reg[0]) && $stable(trim_reg[1])
            && $stable(trim_reg[2]) && $stable(trim_reg[3]))
        else $error("Trims moved while the clock enable was low.");
    chk_delay_freeze: assert property (
        s_frozen |=> $stable(ovl_reg) && $stable(mux_reg)
            && $stable(noise_reg) && $stable(rd_reg))
        else $error("Settings moved while the clock enable was low.");
    chk_trim_a_write: assert property (
        clk_en && wr_en && reg_addr == OFS_TRIM_A
            |=> trim_reg[0] == $past(wr_data))
        else $error("Trim A write was not stored.");
    chk_trim_c_write: assert property (
        clk_en && wr_en && reg_addr == OFS_TRIM_C
            |=> trim_reg[2] == $past(wr_data))
        else $error("Trim C write was not stored.");
    chk_trim_d_write: assert property (
        clk_en && wr_en && reg_addr == OFS_TRIM_D
            |=> trim_reg[3] == $past(wr_data))
        else $error("Trim D write was not stored.");
    chk_noise_write: assert property (
        clk_en && wr_en && reg_addr == OFS_NOISE
            |=> noise_reg == $past(wr_data))
        else $error("Noise control write was not stored.");
    chk_trim_a_readback: assert property (
        clk_en && rd_en && reg_addr == OFS_TRIM_A
            |=> rd_reg == $past(trim_reg[0]))
        else $error("Trim A read returned the wrong value.");
    chk_trim_b_readback: assert property (
        clk_en && rd_en && reg_addr == OFS_TRIM_B
            |=> rd_reg == $past(trim_reg[1]))
        else $error("Trim B read returned the wrong value.");
    chk_trim_d_readback: assert property (
        clk_en && rd_en && reg_addr == OFS_TRIM_D
            |=> rd_reg == $past(trim_reg[3]))
        else $error("Trim D read returned the wrong value.");
    chk_ovl_readback: assert property (
        clk_en && rd_en && reg_addr == OFS_OVL
            |=> rd_reg == $past(ovl_reg))
        else $error("Overlap delay read returned the wrong value.");
    chk_mux_readback: assert property (
        clk_en && rd_en && reg_addr == OFS_MUX
            |=> rd_reg == $past(mux_reg))
        else $error("Mux delay read returned the wrong value.");
    chk_noise_readback: assert property (
        clk_en && rd_en && reg_addr == OFS_NOISE
            |=> rd_reg == $past(noise_reg))
        else $error("Noise control read returned the wrong value.");
    chk_unmapped_write: assert property (
        clk_en && wr_en && reg_addr == OFS_MUX + ADDR_W'(1)
            |=> $stable(ovl_reg) && $stable(mux_reg) && $stable(noise_reg))
        else $error("Unmapped write changed a setting.");

endmodule : tsd_regs

/* File: design/tsd_swap_timer.sv */
`timescale 1ns/1ps
module tsd_swap_timer
(
    // Clock, reset and enable
    input  wire logic                     clk_sys,
    input  wire logic                     rst_n,
    input  wire logic                     clk_en,
    // Calibration engine
    input  wire logic                     swap_start,
    input  wire logic                     swap_target,
    input  wire logic                     steer_req,
    // Delay settings
    input  wire logic [tsd_pkg::DLY_W-1:0] ovl_dly,
    input  wire logic [tsd_pkg::DLY_W-1:0] mux_dly,
    // Swap state
    output logic                          overlap_active,
    output logic                          steer_sel,
    output logic                          swap_busy
);
    import tsd_pkg::*;

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] win_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [CNT_W-1:0] mdly_ext;
    logic [DLY_W-1:0] mdly_reg;
    logic             tgt_reg;
    logic             busy_reg;
    logic             ovl_reg;
    logic             sel_reg;
    logic             start_ok;

    assign start_ok = swap_start && !busy_reg;
    assign cnt_next = cnt_reg + CNT_STEP;
    assign mdly_ext = {2'b00, mdly_reg};

    // ****************************************************************
    // Swap sequencing
    // ****************************************************************
    // Delays are latched at the start so a write mid-swap waits.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_reg <= 1'b0;
            cnt_reg  <= RST_CNT;
            win_reg  <= RST_CNT;
            mdly_reg <= RST_DLY;
            tgt_reg  <= 1'b0;
        end
        else if (clk_en)
        begin
            if (start_ok)
            begin
                busy_reg <= 1'b1;
                cnt_reg  <= RST_CNT;
                win_reg  <= SWAP_BASE_CYC + {1'b0, ovl_dly, 1'b0};
                mdly_reg <= mux_dly;
                tgt_reg  <= swap_target;
            end
            else if (busy_reg)
            begin
                cnt_reg <= cnt_next;
                if (cnt_next >= win_reg && cnt_reg >= mdly_ext)
                    busy_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            ovl_reg <= 1'b0;
        else if (clk_en)
        begin
            if (start_ok)
                ovl_reg <= 1'b1;
            else if (busy_reg)
                ovl_reg <= (cnt_next < win_reg);
            else
                ovl_reg <= 1'b0;
        end
    end

    // Outside a swap the select follows the request with no added delay.
    // A zero delay switches at the start edge, so the field adds its value.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            sel_reg <= 1'b0;
        else if (clk_en)
        begin
            if (start_ok && mux_dly == RST_DLY)
                sel_reg <= swap_target;
            else if (!busy_reg)
                sel_reg <= steer_req;
            else if (cnt_next == mdly_ext)
                sel_reg <= tgt_reg;
        end
    end

    assign overlap_active = ovl_reg;
    assign steer_sel      = sel_reg;
    assign swap_busy      = busy_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_start;
        clk_en && swap_start && !busy_reg;
    endsequence

    chk_swap_latch: assert property (
        s_start |=> ovl_reg && cnt_reg == RST_CNT
            && mdly_reg == $past(mux_dly)
            && win_reg == SWAP_BASE_CYC + {1'b0, $past(ovl_dly), 1'b0})
        else $error("Swap start did not latch the delays.");
    chk_overlap_len: assert property (
        $fell(ovl_reg) |-> cnt_reg == win_reg)
        else $error("Overlap window length is wrong.");
    chk_steer_hold: assert property (
        clk_en && busy_reg && cnt_next != mdly_ext |=> $stable(sel_reg))
        else $error("Steer select moved before its delay.");
    chk_steer_switch: assert property (
        clk_en && busy_reg && cnt_next == mdly_ext |=> sel_reg == tgt_reg)
        else $error("Steer select missed its switch cycle.");
    chk_steer_zero: assert property (
        s_start && mux_dly == RST_DLY |=> sel_reg == $past(swap_target))
        else $error("Zero mux delay did not switch at once.");
    chk_steer_idle: assert property (
        clk_en && !busy_reg && !(swap_start && mux_dly == RST_DLY)
            |=> sel_reg == $past(steer_req))
        else $error("Idle steering was delayed.");

endmodule : tsd_swap_timer

/* File: testbench/trim_and_swap_delay_regs_bench.sv */
`timescale 1ns/1ps
module trim_and_swap_delay_regs_bench;
    import tsd_pkg::*;

    // ****************************************************************
    // Signals
    // ****************************************************************
    logic              clk_sys;
    logic              rst_n;
    logic              clk_en;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] wr_data;
    logic              wr_en;
    logic              rd_en;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] fuse_trim_a;
    logic [DATA_W-1:0] fuse_trim_b;
    logic [DATA_W-1:0] fuse_trim_c;
    logic [DATA_W-1:0] fuse_trim_d;
    logic              swap_start;
    logic              swap_target;
    logic              steer_req;
    logic [DATA_W-1:0] trim_a;
    logic [DATA_W-1:0] trim_b;
    logic [DATA_W-1:0] trim_c;
    logic [DATA_W-1:0] trim_d;
    logic [DATA_W-1:0] noise_ctrl;
    logic              overlap_active;
    logic              steer_sel;
    logic              swap_busy;
    logic [DATA_W-1:0] model [0:255];
    logic [ADDR_W-1:0] addrs [0:7];
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    logic              r;
    int                n_errors = 0;
    int                n_tests  = 0;
    int                cycles   = 0;

    tsd_regs dut
    (
        .clk_sys        (clk_sys),
        .rst_n          (rst_n),
        .clk_en         (clk_en),
        .reg_addr       (reg_addr),
        .wr_data        (wr_data),
        .wr_en          (wr_en),
        .rd_en          (rd_en),
        .rd_data        (rd_data),
        .fuse_trim_a    (fuse_trim_a),
        .fuse_trim_b    (fuse_trim_b),
        .fuse_trim_c    (fuse_trim_c),
        .fuse_trim_d    (fuse_trim_d),
        .swap_start     (swap_start),
        .swap_target    (swap_target),
        .steer_req      (steer_req),
        .trim_a         (trim_a),
        .trim_b         (trim_b),
        .trim_c         (trim_c),
        .trim_d         (trim_d),
        .noise_ctrl     (noise_ctrl),
        .overlap_active (overlap_active),
        .steer_sel      (steer_sel),
        .swap_busy      (swap_busy)
    );

    always #5 clk_sys = ~clk_sys;

    // ****************************************************************
    // Checking and closing
    // ****************************************************************
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
        begin
            $display("Finished cleanly");
        end
        else
        begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: seen %0h expected %0h",
                     $time, seen, exp);
        end
    endtask : check

    // A hang in a swap wait is cut short here.
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_errors++;
            conclude();
        end
    end

    // ****************************************************************
    // Expectations and bus cycles
    // ****************************************************************
    function automatic logic is_mapped(input logic [7:0] x);
        return (x >= OFS_TRIM_A && x <= OFS_TRIM_D) || x == OFS_OVL ||
               x == OFS_MUX || x == OFS_NOISE;
    endfunction : is_mapped

    // Upper bits of the delay and noise registers keep their defaults.
    function automatic logic [7:0] mask_of(input logic [7:0] x);
        if (x == OFS_OVL || x == OFS_MUX)
            return 8'h1F;
        if (x == OFS_NOISE)
            return 8'h07;
        return 8'hFF;
    endfunction : mask_of

    task automatic wr(input logic [7:0] x, input logic [7:0] v);
        @(posedge clk_sys);
        wr_en    <= 1'b1;
        reg_addr <= x;
        wr_data  <= v;
        @(posedge clk_sys);
        wr_en <= 1'b0;
        if (is_mapped(x))
            model[x] = v;
    endtask : wr

    task automatic rd_check(input logic [7:0] x);
        @(posedge clk_sys);
        rd_en    <= 1'b1;
        reg_addr <= x;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        check(rd_data, model[x]);
    endtask : rd_check

    task automatic check_outs();
        check({trim_a, trim_b, trim_c, trim_d, noise_ctrl},
              {model[OFS_TRIM_A], model[OFS_TRIM_B], model[OFS_TRIM_C],
               model[OFS_TRIM_D], model[OFS_NOISE]});
    endtask : check_outs

    // Steer request is held opposite to the target, so a leak of it
    // into the select after the switch shows up as a mismatch.
    task automatic swap(input logic t, input logic [4:0] nm);
        int w;
        int m;
        int b;
        w = 4 + 2 * int'(model[OFS_OVL][4:0]);
        m = int'(model[OFS_MUX][4:0]);
        b = (w > m + 1) ? w : m + 1;
        @(posedge clk_sys);
        steer_req <= ~t;
        @(posedge clk_sys);
        swap_start  <= 1'b1;
        swap_target <= t;
        @(posedge clk_sys);
        swap_start <= 1'b0;
        for (int i = 1; i <= b; i++)
        begin
            #1;
            check({overlap_active, steer_sel, swap_busy},
                  {(i <= w), (i > m) ? t : ~t, 1'b1});
            wr_en      <= (i == 2);
            reg_addr   <= OFS_MUX;
            wr_data    <= {3'h0, nm};
            swap_start <= (i == 3);
            @(posedge clk_sys);
        end
        model[OFS_MUX] = {3'h0, nm};
        #1;
        check({overlap_active, swap_busy}, 2'b00);
    endtask : swap

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        void'($urandom(32'hDBAD9761));
        clk_sys     = 1'b0;
        rst_n       = 1'b0;
        clk_en      = 1'b1;
        reg_addr    = 8'h00;
        wr_data     = 8'h00;
        wr_en       = 1'b0;
        rd_en       = 1'b0;
        swap_start  = 1'b0;
        swap_target = 1'b0;
        steer_req   = 1'b0;
        fuse_trim_a = 8'($urandom);
        fuse_trim_b = 8'($urandom);
        fuse_trim_c = 8'($urandom);
        fuse_trim_d = 8'($urandom);
        addrs = '{OFS_TRIM_A, OFS_TRIM_B, OFS_TRIM_C, OFS_TRIM_D,
                  OFS_OVL, OFS_MUX, OFS_NOISE, 8'h9C};
        for (int k = 0; k < 256; k++)
            model[k] = RD_UNMAPPED;
        model[OFS_TRIM_A] = fuse_trim_a;
        model[OFS_TRIM_B] = fuse_trim_b;
        model[OFS_TRIM_C] = fuse_trim_c;
        model[OFS_TRIM_D] = fuse_trim_d;
        model[OFS_OVL]    = RST_OVL;
        model[OFS_MUX]    = RST_MUX;
        model[OFS_NOISE]  = RST_NOISE;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        check_outs();
        for (int k = 0; k < 8; k++)
            rd_check(addrs[k]);
        // Register traffic with boundary data and an unmapped hole.
        for (int k = 0; k < 80; k++)
        begin
            a = (k < 16) ? addrs[k % 8] : addrs[$urandom_range(7, 0)];
            if (k % 10 == 9)
                a = 8'($urandom);
            d = (k % 3 == 0) ? 8'hFF : (k % 3 == 1) ? 8'h00 : 8'($urandom);
            if (k < 16 || $urandom_range(1, 0) == 1)
                wr(a, d & mask_of(a));
            #1;
            check_outs();
            rd_check(a);
        end
        // A low clock enable must drop a write and hold the trim and noise control outputs.
        clk_en <= 1'b0;
        d = model[OFS_TRIM_A];
        wr(OFS_TRIM_A, ~d);
        model[OFS_TRIM_A] = d;
        #1;
        check_outs();
        clk_en <= 1'b1;
        rd_check(OFS_TRIM_A);
        // Swaps: first with the delays the register traffic left, then the corners, then random.
        for (int k = 0; k < 10; k++)
        begin
            // Calibration is idle between swaps, so the overlap may change.
            if (k == 1)
                wr(OFS_OVL, 8'h00);
            else if (k == 2)
                wr(OFS_OVL, 8'h1F);
            else if (k == 3)
                wr(OFS_OVL, 8'h07);
            else if (k > 3)
                wr(OFS_OVL, 8'($urandom_range(31, 0)));
            // Later mux delays switch inside even the shortest overlap.
            if (k < 3)
                swap(1'($urandom), (k == 0) ? 5'h1F : (k == 1) ? 5'h00
                                   : 5'($urandom));
            else
                swap(1'($urandom), 5'($urandom_range(3, 0)));
            for (int j = 0; j < 6; j++)
            begin
                r = 1'($urandom);
                steer_req <= r;
                @(posedge clk_sys);
                #1;
                check(steer_sel, r);
            end
        end
        rd_check(OFS_MUX);
        conclude();
    end

endmodule : trim_and_swap_delay_regs_bench
